// [hdl/ipps_top.sv]
// ipps_top: priority registers, pin sense control and external request flags
// of the interrupt controller, with request selection toward the cpu.
// assumes pins are asynchronous to clk; cpu, transfer controller and
// peripheral request inputs are synchronous to clk.
//
// What this block does
// - eight 16-bit read/write priority registers giving levels 0 to 15.
// - each priority register holds four 4-bit fields at 15:12, 11:8, 7:4, 3:0.
// - field value zero is lowest level, all ones is highest level fifteen.
// - fields map to lines 0-7, dma, timers, serial, converter, watchdog/bus, io.
// - one shared field gives the same level to every source sharing it.
// - priority registers clear on power-on and manual reset, hold in standby.
// - pin sense control resets on power-on only, holds in standby.
// - control bit 15 reads the nonmaskable pin level, writes ignored.
// - control bits 14 to 9 read zero; software writes zero.
// - control bit 8 picks falling (0) or rising (1) nonmaskable edge.
// - control bits 7 to 0 pick low level or falling edge for lines 0-7.
// - request flags reset on power-on and manual reset, hold in standby.
// - flag register bits 15 to 8 read zero; software writes zero.
// - flag bits 7 down to 0 belong to lines 0 through 7.
// - level sensed flag reads one while the line is low.
// - edge sensed flag sets on a falling edge and holds.
// - edge flag clears on writing zero after reading it as one.
// - edge flag clears when the cpu takes that line's exception.
// - edge flag clears when a transfer triggered by that line completes.
// - equal levels resolve by fixed default order, then position in field.
// - request forwarded only when level exceeds the cpu mask level.
// - edge pending requests are discarded by power-on or manual reset.
// - request output pin goes low and mirrors the request to the cpu.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps

module ipps_top (
    input  wire logic        clk,
    input  wire logic        reset_n,          // power-on reset
    input  wire logic        manual_reset,     // synchronous manual reset
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // external pins
    input  wire logic        nmi_pin,
    input  wire logic [7:0]  irq_pin_n,        // bit i is line i, active low
    output logic             request_output_pin_n,
    // on-chip peripheral requests, one per field 8..29
    input  wire logic [29:8] periph_req,
    input  wire logic        bus_controller_req, // shares field 28 with watchdog
    // cpu side
    input  wire logic [3:0]  cpu_mask_level,
    output logic             cpu_int_req,
    output logic [3:0]       cpu_int_level,
    output logic [4:0]       cpu_int_field,
    output logic             cpu_int_sub,      // 1 = bus controller in field 28
    input  wire logic        cpu_exc_ack,      // one-cycle pulse
    input  wire logic [4:0]  cpu_exc_field,
    output logic             nmi_req,
    input  wire logic        nmi_ack,          // one-cycle pulse
    // data transfer controller
    input  wire logic        xfer_done,        // one-cycle pulse
    input  wire logic [2:0]  xfer_done_line
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] irq_s1_r;
    logic [7:0] irq_s2_r;
    logic [7:0] irq_prev_r;
    logic       nmi_s1_r;
    logic       nmi_s2_r;
    logic       nmi_prev_r;

    // first stage feeds only the second; edges compare stage two with its delay
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_s1_r   <= 8'hff;
            irq_s2_r   <= 8'hff;
            irq_prev_r <= 8'hff;
            nmi_s1_r   <= 1'b1;
            nmi_s2_r   <= 1'b1;
            nmi_prev_r <= 1'b1;
        end else begin
            irq_s1_r   <= irq_pin_n;
            irq_s2_r   <= irq_s1_r;
            irq_prev_r <= irq_s2_r;
            nmi_s1_r   <= nmi_pin;
            nmi_s2_r   <= nmi_s1_r;
            nmi_prev_r <= nmi_s2_r;
        end
    end

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    logic wr_prio;
    logic wr_ctrl;
    logic wr_flags;
    logic rd_flags;

    assign wr_prio  = reg_wr && (reg_addr <= ipps_pkg::ADDR_PRIORITY_WDOG_BUS_IO);
    assign wr_ctrl  = reg_wr && (reg_addr == ipps_pkg::ADDR_PIN_SENSE_CONTROL);
    assign wr_flags = reg_wr && (reg_addr == ipps_pkg::ADDR_EXT_REQUEST_FLAGS);
    assign rd_flags = reg_rd && (reg_addr == ipps_pkg::ADDR_EXT_REQUEST_FLAGS);

    // ------------------------------------------------------------
    // priority registers
    // ------------------------------------------------------------
    logic [15:0] prio_r [ipps_pkg::NUM_PRIO_REGS];

    // cleared by both resets; no standby input, so contents simply hold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ipps_pkg::NUM_PRIO_REGS; i++) begin
                prio_r[i] <= ipps_pkg::PRIO_RESET;
            end
        end else if (manual_reset) begin
            for (int i = 0; i < ipps_pkg::NUM_PRIO_REGS; i++) begin
                prio_r[i] <= ipps_pkg::PRIO_RESET;
            end
        end else if (wr_prio) begin
            prio_r[reg_addr[2:0]] <= reg_wdata;
        end
    end

    // field f sits in register f/4; field 0 of a register is bits 15:12
    logic [3:0] field_lvl [ipps_pkg::NUM_FIELDS];

    for (genvar f = 0; f < ipps_pkg::NUM_FIELDS; f++) begin : g_field
        localparam int LSB = 12 - 4 * (f % 4);
        assign field_lvl[f] = prio_r[f / 4][LSB +: ipps_pkg::FIELD_W];
    end

    // ------------------------------------------------------------
    // pin sense control
    // ------------------------------------------------------------
    logic       nmi_edge_sel_r;
    logic [7:0] sense_sel_r;   // bit 7 is line 0 as in the register

    // power-on reset only; manual reset leaves the sense modes alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_edge_sel_r <= ipps_pkg::CTRL_RESET[8];
            sense_sel_r    <= ipps_pkg::CTRL_RESET[7:0];
        end else if (wr_ctrl) begin
            nmi_edge_sel_r <= reg_wdata[ipps_pkg::CTRL_NMI_EDGE_BIT];
            sense_sel_r    <= reg_wdata[ipps_pkg::CTRL_SENSE_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // external line flags
    // ------------------------------------------------------------
    logic [7:0] edge_flag_r;   // index is line number
    logic [7:0] armed_r;       // flag was read as one since last clear
    logic [7:0] line_edge_mode;
    logic [7:0] line_req;
    logic [7:0] fall;
    logic [7:0] clr_now;

    for (genvar l = 0; l < ipps_pkg::NUM_LINES; l++) begin : g_line
        assign line_edge_mode[l] = sense_sel_r[7 - l];
        assign fall[l]           = irq_prev_r[l] && !irq_s2_r[l];
        assign line_req[l]       = line_edge_mode[l] ? edge_flag_r[l]
                                                     : !irq_s2_r[l];
        // any of the three clear sources for this line
        assign clr_now[l] = (wr_flags && armed_r[l] && !reg_wdata[7 - l])
                         || (cpu_exc_ack && cpu_exc_field == 5'(l))
                         || (xfer_done && xfer_done_line == 3'(l));
    end

    // a falling edge in the clearing cycle wins, so no request is lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_flag_r <= ipps_pkg::FLAGS_RESET;
        end else if (manual_reset) begin
            edge_flag_r <= ipps_pkg::FLAGS_RESET;
        end else begin
            edge_flag_r <= (fall & line_edge_mode)
                         | (edge_flag_r & ~clr_now);
        end
    end

    // arming: a read that returns one for the line arms its zero-write clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_r <= 8'h00;
        end else if (manual_reset) begin
            armed_r <= 8'h00;
        end else begin
            for (int l = 0; l < ipps_pkg::NUM_LINES; l++) begin
                if (wr_flags && !reg_wdata[7 - l]) begin
                    armed_r[l] <= 1'b0;
                end else if (rd_flags && line_edge_mode[l] && edge_flag_r[l]) begin
                    armed_r[l] <= 1'b1;
                end else if (!edge_flag_r[l]) begin
                    armed_r[l] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    logic [7:0]  flags_view;

    for (genvar l = 0; l < ipps_pkg::NUM_LINES; l++) begin : g_view
        assign flags_view[7 - l] = line_req[l];
    end

    always_comb begin
        rd_mux = 16'h0000;
        if (reg_addr <= ipps_pkg::ADDR_PRIORITY_WDOG_BUS_IO) begin
            rd_mux = prio_r[reg_addr[2:0]];
        end else if (reg_addr == ipps_pkg::ADDR_PIN_SENSE_CONTROL) begin
            rd_mux[ipps_pkg::CTRL_NMI_LEVEL_BIT] = nmi_s2_r;
            rd_mux[ipps_pkg::CTRL_NMI_EDGE_BIT]  = nmi_edge_sel_r;
            rd_mux[7:0]                          = sense_sel_r;
        end else if (reg_addr == ipps_pkg::ADDR_EXT_REQUEST_FLAGS) begin
            rd_mux[7:0] = flags_view;
        end
    end

    // unmapped indexes read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // nonmaskable request
    // ------------------------------------------------------------
    logic nmi_edge;

    assign nmi_edge = nmi_edge_sel_r ? (!nmi_prev_r && nmi_s2_r)
                                     : (nmi_prev_r && !nmi_s2_r);

    // edge pending, so discarded by either reset; a new edge beats the ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nmi_req <= 1'b0;
        end else if (manual_reset) begin
            nmi_req <= 1'b0;
        end else begin
            nmi_req <= nmi_edge || (nmi_req && !nmi_ack);
        end
    end

    // ------------------------------------------------------------
    // request selection
    // ------------------------------------------------------------
    logic [31:0] field_req;
    logic [3:0]  best_lvl;
    logic [4:0]  best_field;
    logic        best_any;

    always_comb begin
        field_req                   = 32'h0000_0000;
        field_req[7:0]              = line_req;
        field_req[29:8]             = periph_req;
        field_req[ipps_pkg::WDOG_BUS_FIELD] = periph_req[ipps_pkg::WDOG_BUS_FIELD]
                                            || bus_controller_req;
    end

    // scan from the lowest default priority up; ">=" lets lower indexes win ties
    always_comb begin
        best_lvl   = 4'h0;
        best_field = 5'h00;
        best_any   = 1'b0;
        for (int f = ipps_pkg::LAST_USED; f >= 0; f--) begin
            if (field_req[f] && (!best_any || field_lvl[f] >= best_lvl)) begin
                best_lvl   = field_lvl[f];
                best_field = 5'(f);
                best_any   = 1'b1;
            end
        end
    end

    // registered request; the pin is the same signal inverted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_int_req   <= 1'b0;
            cpu_int_level <= 4'h0;
            cpu_int_field <= 5'h00;
            cpu_int_sub   <= 1'b0;
        end else if (manual_reset) begin
            cpu_int_req   <= 1'b0;
            cpu_int_level <= 4'h0;
            cpu_int_field <= 5'h00;
            cpu_int_sub   <= 1'b0;
        end else begin
            cpu_int_req   <= best_any && (best_lvl > cpu_mask_level);
            cpu_int_level <= best_lvl;
            cpu_int_field <= best_field;
            // watchdog ranks above bus controller inside the shared field
            cpu_int_sub   <= (best_field == 5'(ipps_pkg::WDOG_BUS_FIELD))
                          && !periph_req[ipps_pkg::WDOG_BUS_FIELD];
        end
    end

    assign request_output_pin_n = !cpu_int_req;

endmodule

// [pkg/ipps_pkg.sv]
// ipps_pkg: constants shared by the interrupt priority and pin sense block.
// assumes a word-indexed register port with 16-bit data.
package ipps_pkg;

    // ------------------------------------------------------------
    // register indexes on the register port
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PRIORITY_EXT_LINES_LOW  = 4'h0;
    localparam logic [3:0] ADDR_PRIORITY_EXT_LINES_HIGH = 4'h1;
    localparam logic [3:0] ADDR_PRIORITY_DMA_CHANNELS   = 4'h2;
    localparam logic [3:0] ADDR_PRIORITY_TIMER_UNITS_A  = 4'h3;
    localparam logic [3:0] ADDR_PRIORITY_TIMER_UNITS_B  = 4'h4;
    localparam logic [3:0] ADDR_PRIORITY_TIMER_SERIAL   = 4'h5;
    localparam logic [3:0] ADDR_PRIORITY_CONV_XFER_CMP  = 4'h6;
    localparam logic [3:0] ADDR_PRIORITY_WDOG_BUS_IO    = 4'h7;
    localparam logic [3:0] ADDR_PIN_SENSE_CONTROL       = 4'h8;
    localparam logic [3:0] ADDR_EXT_REQUEST_FLAGS       = 4'h9;

    // ------------------------------------------------------------
    // sizes and field layout
    // ------------------------------------------------------------
    localparam int NUM_PRIO_REGS  = 8;
    localparam int NUM_FIELDS     = 32;   // four 4-bit fields per register
    localparam int NUM_LINES      = 8;
    localparam int FIELD_W        = 4;
    localparam int FIRST_PERIPH   = 8;    // fields 0..7 are the external lines
    localparam int WDOG_BUS_FIELD = 28;   // shared by watchdog and bus controller
    localparam int LAST_USED      = 29;   // fields 30 and 31 are reserved

    localparam logic [15:0] PRIO_RESET  = 16'h0000;
    localparam logic [8:0]  CTRL_RESET  = 9'h000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    // pin sense control bits
    localparam int CTRL_NMI_LEVEL_BIT = 15;
    localparam int CTRL_NMI_EDGE_BIT  = 8;
    localparam int CTRL_SENSE_MSB     = 7;

endpackage

// [sim/ipps_checker.sv]
// ipps_checker: port-level assertions for the priority and pin sense block.
// assumes it is bound to ipps_top and sees only its ports.
`timescale 1ns/1ps
module ipps_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        manual_reset,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        nmi_pin,
    input wire logic        request_output_pin_n,
    input wire logic [3:0]  cpu_mask_level,
    input wire logic        cpu_int_req,
    input wire logic [3:0]  cpu_int_level,
    input wire logic        nmi_req,
    input wire logic        nmi_ack
);
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rdata_quiet: assert property (
        reg_rdata != 16'h0000 |-> $past(reg_rd)) else $error("read data outside its slot");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (
        reg_rd && reg_addr == 4'h8 |=> reg_rdata[14:9] == 6'h00) else $error("control spare bits");
    a_flag_reserved: assert property (
        reg_rd && reg_addr == 4'h9 |=> reg_rdata[15:8] == 8'h00) else $error("flag spare bits");
    // the pin passes two sync stages, so only a settled level is compared
    a_nmi_level_bit: assert property (
        ($stable(nmi_pin) [*4] ##0 (reg_rd && reg_addr == 4'h8)) |=> reg_rdata[15] == $past(nmi_pin))
        else $error("nmi level bit wrong");
    a_mask_gate: assert property (
        cpu_int_req |-> cpu_int_level > $past(cpu_mask_level)) else $error("request not above mask");
    a_pin_mirror: assert property (
        request_output_pin_n == !cpu_int_req) else $error("request pin not mirroring");
    a_nmi_hold: assert property (
        nmi_req && !nmi_ack && !manual_reset |=> nmi_req) else $error("nmi request dropped early");
endmodule

// [sim/ipps_cpu_model.sv]
// ipps_cpu_model: behavioural cpu core taking interrupt and nmi requests.
// assumes clk and reset_n shared with the block; the bench sets ack_en and ack_delay.
`timescale 1ns/1ps
module ipps_cpu_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    input  wire logic       cpu_int_req,
    input  wire logic [4:0] cpu_int_field,
    input  wire logic       nmi_req,
    output logic            cpu_exc_ack,
    output logic [4:0]      cpu_exc_field,
    output logic            nmi_ack
);
    logic [3:0] wait_r;
    // exception entry after a stall; field toggles while unqualified so no stale value helps
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r        <= 4'h0;
            cpu_exc_ack   <= 1'b0;
            cpu_exc_field <= 5'h00;
        end else begin
            cpu_exc_ack   <= 1'b0;
            cpu_exc_field <= ~cpu_exc_field;
            wait_r        <= 4'h0;
            if (ack_en && cpu_int_req && !cpu_exc_ack) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r == ack_delay) begin
                    cpu_exc_ack   <= 1'b1;
                    cpu_exc_field <= cpu_int_field;
                    wait_r        <= 4'h0;
                end
            end
        end
    end
    // nmi is taken at once, one pulse per request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            nmi_ack <= 1'b0;
        else
            nmi_ack <= nmi_req && !nmi_ack;
    end
endmodule

// [sim/tb_interrupt_priority_and_pin_sense.sv]
// tb_interrupt_priority_and_pin_sense: self-checking bench for ipps_top.
// assumes ipps_cpu_model answers the cpu side; reads are checked from a queue.
`timescale 1ns/1ps
module tb_interrupt_priority_and_pin_sense;
    logic        clk = 1'b0, reset_n = 1'b0, manual_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        nmi_pin = 1'b1, bus_controller_req = 1'b0, xfer_done = 1'b0, ack_en = 1'b0;
    logic [3:0]  reg_addr = 4'h0, cpu_mask_level = 4'hf, ack_delay = 4'h0, cpu_int_level;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [7:0]  irq_pin_n = 8'hff;
    logic [29:8] periph_req = 22'h000000;
    logic [2:0]  xfer_done_line = 3'h0;
    logic [4:0]  cpu_int_field, cpu_exc_field;
    logic        request_output_pin_n, cpu_int_req, cpu_int_sub, cpu_exc_ack, nmi_req, nmi_ack;
    logic        rd_q = 1'b0;
    logic [19:0] exp_q[$];
    logic [19:0] e;
    logic [15:0] v[8];
    integer      seed = 37073;
    int          err_count = 0, check_count = 0, nmi_acks = 0;

    ipps_top uut (.clk(clk), .reset_n(reset_n), .manual_reset(manual_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
        .request_output_pin_n(request_output_pin_n), .periph_req(periph_req),
        .bus_controller_req(bus_controller_req), .cpu_mask_level(cpu_mask_level),
        .cpu_int_req(cpu_int_req), .cpu_int_level(cpu_int_level), .cpu_int_field(cpu_int_field),
        .cpu_int_sub(cpu_int_sub), .cpu_exc_ack(cpu_exc_ack), .cpu_exc_field(cpu_exc_field),
        .nmi_req(nmi_req), .nmi_ack(nmi_ack), .xfer_done(xfer_done),
        .xfer_done_line(xfer_done_line));
    ipps_cpu_model cpu (.clk(clk), .reset_n(reset_n), .ack_en(ack_en), .ack_delay(ack_delay),
        .cpu_int_req(cpu_int_req), .cpu_int_field(cpu_int_field), .nmi_req(nmi_req),
        .cpu_exc_ack(cpu_exc_ack), .cpu_exc_field(cpu_exc_field), .nmi_ack(nmi_ack));

    always #20 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // the expected word is queued when the read is issued
    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({a, x});
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    // five edges cover the sync stages and the flag update
    task automatic pins(input logic [7:0] p);
        @(posedge clk);
        irq_pin_n <= p;
        repeat (5) @(posedge clk);
    endtask
    // one edge more than pins, so the ack count has settled before any compare
    task automatic nmi_to(input logic lvl);
        @(posedge clk);
        nmi_pin <= lvl;
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_req(input logic lvl);
        int n = 0;
        while (cpu_int_req !== lvl && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (cpu_int_req !== lvl) begin
            err_count++;
            results();
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] p);
        for (int b = 0; b < 8; b++) rev[b] = p[7 - b];
    endfunction

    // read data stand one cycle after the strobe, so the monitor lags by one edge
    always @(posedge clk) begin
        if (rd_q) begin
            e = exp_q.pop_front();
            check($sformatf("reg %0h", e[19:16]), reg_rdata, e[15:0]);
        end
        rd_q <= reg_rd;
        if (nmi_ack === 1'b1) nmi_acks++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0000);
        rd(4'h8, 16'h8000);
        rd(4'h9, 16'h0000);
        rd(4'ha, 16'h0000);
        for (int a = 0; a < 8; a++) begin
            v[a] = 16'($random(seed));
            wr(a[3:0], v[a]);
        end
        for (int a = 0; a < 8; a++) rd(a[3:0], v[a]);
        // reserved bits are written as zero; bit 15 written zero must still show the pin
        wr(4'h8, 16'h01ff);
        rd(4'h8, 16'h81ff);
        wr(4'h9, 16'h0000);
        rd(4'h9, 16'h0000);
        // level sensing: flags follow the pins, line 0 lands in bit 7
        wr(4'h8, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v[0] = 16'($random(seed));
            pins(v[0][7:0]);
            rd(4'h9, {8'h00, ~rev(v[0][7:0])});
        end
        pins(8'hff);
        nmi_to(1'b0);
        rd(4'h8, 16'h0000);
        nmi_to(1'b1);
        check("nmi entries", 16'(nmi_acks), 16'h0001);
        wr(4'h8, 16'h01ff);
        nmi_to(1'b0);
        nmi_to(1'b1);
        check("nmi entries", 16'(nmi_acks), 16'h0002);
        // edge sensing: a zero written before any read must not withdraw
        wr(4'h0, 16'h5500);
        wr(4'h1, 16'h0000);
        pins(8'hf6);
        pins(8'hff);
        wr(4'h9, 16'h0000);
        rd(4'h9, 16'h0090);
        wr(4'h9, 16'h0080);
        rd(4'h9, 16'h0080);
        @(posedge clk);
        xfer_done <= 1'b1;
        @(posedge clk);
        xfer_done <= 1'b0;
        rd(4'h9, 16'h0000);
        // equal levels on lines 0 and 1; a mask equal to the level holds them back
        cpu_mask_level <= 4'h5;
        ack_en         <= 1'b1;
        ack_delay      <= 4'h3;
        pins(8'hfc);
        pins(8'hff);
        check("request", {15'h0000, cpu_int_req}, 16'h0000);
        cpu_mask_level <= 4'h4;
        wait_req(1'b1);
        check("level", {12'h000, cpu_int_level}, 16'h0005);
        check("field", {11'h000, cpu_int_field}, 16'h0000);
        check("out pin", {15'h0000, request_output_pin_n}, 16'h0000);
        wait_req(1'b0);
        rd(4'h9, 16'h0000);
        // shared watchdog/bus field: bus controller alone, then watchdog beside it
        ack_en <= 1'b0;
        wr(4'h7, 16'h7000);
        bus_controller_req <= 1'b1;
        wait_req(1'b1);
        check("field", {11'h000, cpu_int_field}, 16'h001c);
        check("level", {12'h000, cpu_int_level}, 16'h0007);
        check("sub", {15'h0000, cpu_int_sub}, 16'h0001);
        @(posedge clk);
        periph_req[28] <= 1'b1;
        repeat (2) @(negedge clk);
        check("sub", {15'h0000, cpu_int_sub}, 16'h0000);
        @(posedge clk);
        bus_controller_req <= 1'b0;
        periph_req         <= 22'h000000;
        wait_req(1'b0);
        // manual reset drops levels and held edges but keeps sense control
        pins(8'hfb);
        pins(8'hff);
        @(posedge clk);
        manual_reset <= 1'b1;
        @(posedge clk);
        manual_reset <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h8, 16'h81ff);
        rd(4'h9, 16'h0000);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(4'h8, 16'h8000);
        repeat (3) @(posedge clk);
        results();
    end
endmodule

bind ipps_top ipps_checker u_chk (.clk(clk), .reset_n(reset_n), .manual_reset(manual_reset),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
    .request_output_pin_n(request_output_pin_n), .cpu_mask_level(cpu_mask_level),
    .cpu_int_req(cpu_int_req), .cpu_int_level(cpu_int_level), .nmi_req(nmi_req),
    .nmi_ack(nmi_ack));
